/* rtl/tmpl_pkg.sv */
/*
 * shared constants and types for the timer mode priority logic.
 * assumes one peripheral clock and a software command port on that clock.
 */
`default_nettype none
package tmpl_pkg;

   // ****************************************************************
   // widths and constants
   // ****************************************************************
   localparam int          IO_W        = 16;
   localparam int          LM_W        = 32;
   localparam int          PRE_W       = 8;
   localparam logic [15:0] IO_ONES     = 16'hffff;
   localparam logic [15:0] IO_ZERO     = 16'h0000;
   localparam logic [15:0] IO_ONE      = 16'h0001;
   localparam logic [31:0] LM_ZERO     = 32'h0000_0000;
   localparam logic [31:0] LM_ONE      = 32'h0000_0001;
   localparam logic [7:0]  PRE_ZERO    = 8'h00;
   localparam logic [7:0]  PRE_ONE     = 8'h01;

   // ****************************************************************
   // modes and states
   // ****************************************************************
   typedef enum logic [1:0] {
      TMPL_IO_DELAYED = 2'b01,
      TMPL_IO_CONT    = 2'b10
   } tmpl_io_mode_t;

   typedef enum logic [2:0] {
      TMPL_ST_IDLE = 3'b001,
      TMPL_ST_WAIT = 3'b010,
      TMPL_ST_RUN  = 3'b100
   } tmpl_io_state_t;

   // ****************************************************************
   // software command carrier, one cycle strobes
   // ****************************************************************
   typedef struct packed {
      logic          io_en_wr;
      logic          io_en_val;
      logic          io_reload_wr;
      logic [15:0]   io_reload;
      logic          sm_wr;
      logic [15:0]   sm_wdata;
      logic          lm_wr;
      logic [31:0]   lm_wdata;
   } tmpl_cmd_t;

endpackage : tmpl_pkg
`default_nettype wire

/* rtl/tmpl_prescaler.sv */
/*
 * count clock prescaler: one-cycle tick every div+1 clocks.
 * assumes div is quasi static; a change takes effect in the current period, since the count is compared with div every cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module tmpl_prescaler #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] div,
   output var  logic         tick_q
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         wrap;

   generate
      if (W < 1) begin : g_chk
         $error("prescaler width must be at least one");
      end
   endgenerate

   assign wrap  = (cnt_q >= div);
   assign cnt_d = wrap ? W'(0) : W'(cnt_q + W'(1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= wrap;
      end
   end

endmodule : tmpl_prescaler
`default_nettype wire

/* rtl/tmpl_top.sv */
/*
 * output timer, small and large measure timers with event priority.
 * assumes cmd strobes come from logic on mclk; pins are asynchronous.
 */
// Functional notes
// RULE1 - delayed single-shot: underflow stop beats external pin enable in same period
// RULE2 - delayed single-shot: software enable beats underflow stop, counting continues
// RULE3 - software disable beats external pin enable in same period
// RULE4 - read right after underflow reload gives all ones, then reload minus one
// RULE5 - output flip-flop toggles only after one prescaler tick following enable
// RULE6 - small measure: write and event together load write data into both
// RULE7 - large measure: write loads counter, measure keeps the pre-write count
// RULE8 - software must not write large counter on bus 1 unless half rate
// RULE9 - bus 1 not half rate: capture leads counter by one; half rate exact
// RULE10 - continuous mode reloads at each underflow; single-shot stops after it
`timescale 1ns/1ns
`default_nettype none
module tmpl_top #(
   parameter int PRE_W = tmpl_pkg::PRE_W
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   input  wire tmpl_pkg::tmpl_cmd_t    cmd,
   input  wire tmpl_pkg::tmpl_io_mode_t io_mode,
   input  wire logic [PRE_W-1:0]       pre_div,
   input  wire logic                   lm_bus1_sel,
   input  wire logic                   lm_half_clk,
   input  wire logic                   ext_en_pin,
   input  wire logic                   sm_meas_pin,
   input  wire logic                   lm_meas_pin,
   output var  logic [15:0]            io_cnt_q,
   output var  logic                   io_out_q,
   output var  logic                   io_en_q,
   output var  logic [15:0]            sm_cnt_q,
   output var  logic [15:0]            sm_meas_q,
   output var  logic [31:0]            lm_cnt_q,
   output var  logic [31:0]            lm_meas_q
);

   // ****************************************************************
   // parameter check
   // ****************************************************************
   generate
      if (PRE_W < 1 || PRE_W > 16) begin : g_chk
         $error("prescaler width out of range");
      end
   endgenerate

   // ****************************************************************
   // pin synchronisers and edge detect
   // ****************************************************************
   localparam int NPIN = 3;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] pin_rise;

   assign pin_raw = {lm_meas_pin, sm_meas_pin, ext_en_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
            end
         end
         assign pin_rise[gi] = s2_q[gi] & ~s3_q[gi];
      end
   endgenerate

   logic ext_en_ev;
   logic sm_ev;
   logic lm_ev;
   assign ext_en_ev = pin_rise[0];
   assign sm_ev     = pin_rise[1];
   assign lm_ev     = pin_rise[2];

   // ****************************************************************
   // count clock
   // ****************************************************************
   logic tick;

   tmpl_prescaler #(
      .W      (PRE_W)
   ) u_pre (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .div    (pre_div),
      .tick_q (tick)
   );

   // ****************************************************************
   // output timer decode
   // ****************************************************************
   tmpl_pkg::tmpl_io_state_t io_st_q;
   tmpl_pkg::tmpl_io_state_t io_st_d;
   logic [15:0] io_reload_q;
   logic [15:0] io_cnt_d;
   logic [15:0] reload_m1;
   logic        reload_pend_q;
   logic        uf;
   logic        uf_stop;
   logic        en_d;
   logic        run;

   assign run       = (io_st_q == tmpl_pkg::TMPL_ST_RUN);
   assign uf        = run & tick & (io_cnt_q == tmpl_pkg::IO_ZERO);
   assign uf_stop   = uf & (io_mode == tmpl_pkg::TMPL_IO_DELAYED);    // [RULE10]
   assign reload_m1 = 16'(io_reload_q - tmpl_pkg::IO_ONE);

   // software write first, then underflow stop, then the pin
   assign en_d = cmd.io_en_wr ? cmd.io_en_val :                      // [RULE2] [RULE3]
                 uf_stop      ? 1'b0 :                               // [RULE1]
                 ext_en_ev    ? 1'b1 : io_en_q;

   // waiting for a tick keeps the flip-flop aligned to the count clock
   always_comb begin
      io_st_d = io_st_q;
      unique case (io_st_q)
         tmpl_pkg::TMPL_ST_IDLE: begin
            if (en_d) io_st_d = tmpl_pkg::TMPL_ST_WAIT;
         end
         tmpl_pkg::TMPL_ST_WAIT: begin
            if (!en_d) io_st_d = tmpl_pkg::TMPL_ST_IDLE;
            else if (tick) io_st_d = tmpl_pkg::TMPL_ST_RUN;          // [RULE5]
         end
         tmpl_pkg::TMPL_ST_RUN: begin
            if (!en_d) io_st_d = tmpl_pkg::TMPL_ST_IDLE;
         end
         default: io_st_d = tmpl_pkg::TMPL_ST_IDLE;
      endcase
   end

   // reload shows all ones for one cycle, then reload minus one
   assign io_cnt_d = uf                 ? tmpl_pkg::IO_ONES :         // [RULE4]
                     reload_pend_q      ? reload_m1 :                 // [RULE4]
                     (io_st_q == tmpl_pkg::TMPL_ST_IDLE && en_d) ? io_reload_q :
                     (run && tick)      ? 16'(io_cnt_q - tmpl_pkg::IO_ONE) :
                     io_cnt_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         io_st_q       <= tmpl_pkg::TMPL_ST_IDLE;
         io_en_q       <= 1'b0;
         io_cnt_q      <= tmpl_pkg::IO_ZERO;
         io_reload_q   <= tmpl_pkg::IO_ZERO;
         reload_pend_q <= 1'b0;
         io_out_q      <= 1'b0;
      end else begin
         io_st_q       <= io_st_d;
         io_en_q       <= en_d;
         io_cnt_q      <= io_cnt_d;
         reload_pend_q <= uf;
         if (cmd.io_reload_wr) io_reload_q <= cmd.io_reload;
         if (uf) io_out_q <= ~io_out_q;                               // [RULE5]
      end
   end

   // ****************************************************************
   // small measure timer
   // ****************************************************************
   logic [15:0] sm_cnt_d;
   logic [15:0] sm_meas_d;

   assign sm_cnt_d  = cmd.sm_wr ? cmd.sm_wdata :
                      tick      ? 16'(sm_cnt_q + tmpl_pkg::IO_ONE) : sm_cnt_q;
   assign sm_meas_d = !sm_ev    ? sm_meas_q :
                      cmd.sm_wr ? cmd.sm_wdata : sm_cnt_q;            // [RULE6]

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sm_cnt_q  <= tmpl_pkg::IO_ZERO;
         sm_meas_q <= tmpl_pkg::IO_ZERO;
      end else begin
         sm_cnt_q  <= sm_cnt_d;
         sm_meas_q <= sm_meas_d;
      end
   end

   // ****************************************************************
   // large measure timer
   // ****************************************************************
   logic        half_q;
   logic        lm_tick;
   logic        lm_lead;
   logic [31:0] lm_cap;
   logic [31:0] lm_cnt_d;

   // half rate runs on its own toggle so capture timing stays exact
   assign lm_tick  = lm_half_clk ? half_q : tick;
   assign lm_lead  = lm_bus1_sel & ~lm_half_clk;
   assign lm_cap   = lm_lead ? 32'(lm_cnt_q + tmpl_pkg::LM_ONE) : lm_cnt_q; // [RULE9]
   assign lm_cnt_d = cmd.lm_wr ? cmd.lm_wdata :                       // [RULE7]
                     lm_tick   ? 32'(lm_cnt_q + tmpl_pkg::LM_ONE) : lm_cnt_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         half_q    <= 1'b0;
         lm_cnt_q  <= tmpl_pkg::LM_ZERO;
         lm_meas_q <= tmpl_pkg::LM_ZERO;
      end else begin
         half_q   <= ~half_q;
         lm_cnt_q <= lm_cnt_d;
         if (lm_ev) lm_meas_q <= lm_cap;                              // [RULE7]
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   uf_beats_pin_a: assert property ( // [RULE1]
      uf_stop && ext_en_ev && !cmd.io_en_wr |=> !io_en_q && !run)
      else $error("pin enable overrode underflow stop");

   sw_beats_uf_a: assert property ( // [RULE2]
      uf_stop && cmd.io_en_wr && cmd.io_en_val |=> io_en_q && run)
      else $error("software enable lost to underflow stop");

   sw_dis_wins_a: assert property ( // [RULE3]
      ext_en_ev && cmd.io_en_wr && !cmd.io_en_val |=> !io_en_q ##1 !run)
      else $error("software disable lost to pin enable");

   reload_ones_a: assert property ( // [RULE4]
      uf |=> (io_cnt_q == tmpl_pkg::IO_ONES) ##1 (io_cnt_q == $past(reload_m1)))
      else $error("reload sequence wrong");

   flop_after_tick_a: assert property ( // [RULE5]
      $changed(io_out_q) |-> $past(run) && $past(tick))
      else $error("output toggled without count clock");

   sm_both_load_a: assert property ( // [RULE6]
      sm_ev && cmd.sm_wr |=> sm_cnt_q == $past(cmd.sm_wdata)
                             && sm_meas_q == $past(cmd.sm_wdata))
      else $error("small measure coincidence wrong");

   lm_prewrite_a: assert property ( // [RULE7]
      lm_ev && cmd.lm_wr && !lm_lead |=> lm_cnt_q == $past(cmd.lm_wdata)
                                          && lm_meas_q == $past(lm_cnt_q))
      else $error("large measure did not keep pre-write count");

   lm_lead_one_a: assert property ( // [RULE9]
      lm_ev && lm_lead |=> lm_meas_q == 32'($past(lm_cnt_q) + tmpl_pkg::LM_ONE))
      else $error("large capture lead wrong");

   cont_reload_a: assert property ( // [RULE10]
      uf && io_mode == tmpl_pkg::TMPL_IO_CONT && !cmd.io_en_wr |=> run ##1 run)
      else $error("continuous mode stopped at underflow");

endmodule : tmpl_top
`default_nettype wire

/* test/tb_top.sv */
/*
 * self-checking bench for the timer priority logic.
 * assumes the host model drives all commands and pins at falling edges.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic                    mclk = 1'b0;
   logic                    rst_b = 1'b0;
   tmpl_pkg::tmpl_io_mode_t io_mode = tmpl_pkg::TMPL_IO_CONT;
   logic                    bus1 = 1'b0;
   logic                    half = 1'b0;
   tmpl_pkg::tmpl_cmd_t     cmd;
   logic [2:0]              pins;
   logic [15:0]             io_cnt_q, sm_cnt_q, sm_meas_q;
   logic [31:0]             lm_cnt_q, lm_meas_q, c;
   logic                    io_out_q, io_en_q;
   int                      num_errors = 0;
   int                      compares = 0;
   int                      u, n;

   always #10 mclk = ~mclk;

   tmpl_top #(.PRE_W(8)) u_tmpl_top (.mclk(mclk), .rst_b(rst_b), .cmd(cmd),
      .io_mode(io_mode), .pre_div(8'h02), .lm_bus1_sel(bus1), .lm_half_clk(half),
      .ext_en_pin(pins[0]), .sm_meas_pin(pins[1]), .lm_meas_pin(pins[2]),
      .io_cnt_q(io_cnt_q), .io_out_q(io_out_q), .io_en_q(io_en_q),
      .sm_cnt_q(sm_cnt_q), .sm_meas_q(sm_meas_q), .lm_cnt_q(lm_cnt_q),
      .lm_meas_q(lm_meas_q));
   tmpl_host_model u_tmpl_host_model (.lm_bus1_sel(bus1), .lm_half_clk(half),
      .cmd(cmd), .pins(pins));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic nx(input int k);
      repeat (k) @(negedge mclk);
   endtask : nx

   task automatic put(input tmpl_pkg::tmpl_cmd_t cc, input logic [2:0] p);
      u_tmpl_host_model.put(cc, p);
   endtask : put

   function automatic tmpl_pkg::tmpl_cmd_t en(input logic v);
      en = '0;
      en.io_en_wr = 1'b1;
      en.io_en_val = v;
   endfunction : en

   task automatic rst;
      rst_b = 1'b0;
      nx(2);
      rst_b = 1'b1;
      nx(1);
   endtask : rst

   // reset restarts the prescaler, so the underflow cycle repeats exactly
   task automatic arm(input tmpl_pkg::tmpl_io_mode_t m, input logic [15:0] r);
      tmpl_pkg::tmpl_cmd_t cc;
      rst();
      io_mode = m;
      cc = '0;
      cc.io_reload_wr = 1'b1;
      cc.io_reload = r;
      put(cc, 3'h0);
      nx(1);
      put(en(1'b1), 3'h0);
      nx(1);
      put('0, 3'h0);
   endtask : arm

   task automatic wait_ffff(output int k);
      k = 1;
      while (io_cnt_q !== 16'hffff && k < 100) begin
         nx(1);
         k++;
      end
      if (io_cnt_q !== 16'hffff) begin
         num_errors++;
         $display("[FAIL] %0t underflow wait ran out", $time);
      end
   endtask : wait_ffff

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_cont;
      arm(tmpl_pkg::TMPL_IO_CONT, 16'h0003);
      `CHK(io_cnt_q, 16'h0003)
      wait_ffff(n);
      `CHK(n >= 12, 1'b1)
      `CHK(io_cnt_q, 16'hffff)
      `CHK(io_out_q, 1'b1)
      nx(1);
      `CHK(io_cnt_q, 16'h0002)
      nx(1);
      wait_ffff(n);
      `CHK(io_cnt_q, 16'hffff)
      `CHK(io_en_q, 1'b1)
      $display("test continuous done");
   endtask : t_cont

   task automatic t_delayed;
      arm(tmpl_pkg::TMPL_IO_DELAYED, 16'h0002);
      wait_ffff(u);
      `CHK(io_en_q, 1'b0)
      nx(12);
      `CHK(io_cnt_q, 16'h0001)
      arm(tmpl_pkg::TMPL_IO_DELAYED, 16'h0002);
      nx(u - 4);
      put('0, 3'b001);
      nx(3);
      `CHK(io_cnt_q, 16'hffff)
      `CHK(io_en_q, 1'b0)
      nx(4);
      `CHK(io_en_q, 1'b0)
      put('0, 3'h0);
      arm(tmpl_pkg::TMPL_IO_DELAYED, 16'h0002);
      nx(u - 2);
      put(en(1'b1), 3'h0);
      nx(1);
      put('0, 3'h0);
      `CHK(io_en_q, 1'b1)
      nx(1);
      wait_ffff(n);
      `CHK(io_cnt_q, 16'hffff)
      $display("test delayed done");
   endtask : t_delayed

   task automatic t_pin_vs_sw;
      for (int i = 0; i < 2; i++) begin
         rst();
         io_mode = i ? tmpl_pkg::TMPL_IO_DELAYED : tmpl_pkg::TMPL_IO_CONT;
         put('0, 3'b001);
         nx(2);
         put(en(1'b0), 3'b001);
         nx(1);
         put('0, 3'h0);
         nx(4);
         `CHK(io_en_q, 1'b0)
         put('0, 3'b001);
         nx(4);
         `CHK(io_en_q, 1'b1)
         put('0, 3'h0);
      end
      $display("test pin versus software done");
   endtask : t_pin_vs_sw

   task automatic t_meas;
      tmpl_pkg::tmpl_cmd_t cc;
      rst();
      bus1 = 1'b1;
      half = 1'b1;
      nx(6);
      cc = '0;
      cc.sm_wr = 1'b1;
      cc.sm_wdata = 16'h00a5;
      put('0, 3'b010);
      nx(2);
      put(cc, 3'b010);
      nx(1);
      put('0, 3'h0);
      `CHK(sm_cnt_q, 16'h00a5)
      `CHK(sm_meas_q, 16'h00a5)
      put('0, 3'b100);
      nx(2);
      c = lm_cnt_q;
      nx(1);
      put('0, 3'h0);
      `CHK(lm_meas_q, c)
      nx(3);
      cc = '0;
      cc.lm_wr = 1'b1;
      cc.lm_wdata = 32'h1234_5678;
      put('0, 3'b100);
      nx(2);
      c = lm_cnt_q;
      put(cc, 3'b100);
      nx(1);
      put('0, 3'h0);
      `CHK(lm_cnt_q, 32'h1234_5678)
      `CHK(lm_meas_q, c)
      half = 1'b0;
      nx(3);
      put('0, 3'b100);
      nx(2);
      c = lm_cnt_q;
      nx(1);
      put('0, 3'h0);
      `CHK(lm_meas_q, c + 32'h1)
      bus1 = 1'b0;
      nx(3);
      put('0, 3'b100);
      nx(2);
      c = lm_cnt_q;
      nx(1);
      put('0, 3'h0);
      `CHK(lm_meas_q, c)
      $display("test measure done");
   endtask : t_meas

   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   initial begin
      nx(20);
      rst_b = 1'b1;
      nx(1);
      t_cont();
      t_delayed();
      t_pin_vs_sw();
      t_meas();
      wrap_up();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #(20 * 4000);
      num_errors++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire

/* test/tmpl_host_model.sv */
/*
 * software side of the timer: command strobes and the three trigger pins.
 * assumes the caller changes everything just after a falling edge of mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module tmpl_host_model (
   input  wire logic                lm_bus1_sel,
   input  wire logic                lm_half_clk,
   output var  tmpl_pkg::tmpl_cmd_t cmd,
   output var  logic [2:0]          pins
);
   // ****************************************************************
   // drive
   // ****************************************************************
   initial begin
      cmd  = '0;
      pins = 3'h0;
   end

   task automatic put(input tmpl_pkg::tmpl_cmd_t c, input logic [2:0] p);
      tmpl_pkg::tmpl_cmd_t v;
      v = c;
      // such writes land wrongly, so software leaves them out
      if (lm_bus1_sel && !lm_half_clk) v.lm_wr = 1'b0;
      cmd = v;
      pins = p;
   endtask : put
endmodule : tmpl_host_model
`default_nettype wire
